/* rtl/swm_sleep_seq.sv */
// Sleep entry, wakeup sequencing and supply monitor registers
`timescale 1ns/1ps
module swm_sleep_seq (
    input wire logic ref_clk, // Core clock, 25 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic sleep_set, // Pulse: firmware set the sleep bit
    input wire logic irq_pending, // Any unmasked interrupt pending
    input wire logic cpu_halt_acknowledge, // CPU halt acknowledge
    input wire logic low_speed_clk, // 32 kHz oscillator, asynchronous
    input wire logic precision_reset_comparator, // Reset comparator raw output
    input wire logic undervoltage_detect, // Undervoltage comparator raw output
    input wire logic extended_io_bank_flag, // Second I/O bank selected
    input wire logic [7:0] io_addr, // I/O address within bank
    input wire logic io_wr, // I/O write strobe
    input wire logic io_rd, // I/O read strobe
    input wire logic [7:0] io_wdata, // I/O write data
    output logic [7:0] io_rdata, // I/O read data
    output logic io_hit, // Address matches one of our registers
    output logic cpu_halt_request, // Halt request to CPU
    output logic global_power_down, // Power-down to flash, osc, filter, bandgap
    output logic monitor_enable, // Supply monitor powered
    output logic [1:0] reset_trip_range, // Reset comparator range
    output logic [2:0] undervoltage_trip_select, // Undervoltage threshold
    output logic precision_reset, // Reset request from comparator
    output logic flash_enable, // Flash allowed to run
    output logic undervoltage_event, // Pulse: undervoltage tripped
    output logic wake_done // Pulse: CPU released after wakeup
);
    import swm_pkg::*;

    // ------------------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic srst_n;
    logic [2:0] ls_meta_q, ls_sync_q;
    logic ls_prev_q;
    logic ls_rise, ls_fall;

    // Reset asserts at once, releases after two edges
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign srst_n = rst_sync_q[1];

    // Slow clock and comparators are asynchronous: two flops each
    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            ls_meta_q <= 3'b000;
            ls_sync_q <= 3'b000;
            ls_prev_q <= 1'b0;
        end else if (ce) begin
            ls_meta_q <= {undervoltage_detect, precision_reset_comparator, low_speed_clk};
            ls_sync_q <= ls_meta_q;
            ls_prev_q <= ls_sync_q[0];
        end
    end
    assign ls_rise = ce & ls_sync_q[0] & ~ls_prev_q;
    assign ls_fall = ce & ~ls_sync_q[0] & ls_prev_q;

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    logic [7:0] vlc_q, vlc_d;
    logic [7:0] mdt_q, mdt_d;
    logic [7:0] vcs_q, vcs_d;
    logic [ADDR_W-1:0] full_addr;
    logic sel_vlc, sel_vcs, sel_mdt;
    logic monitor_on;

    // Registers exist only in the second bank, so the flag is part of the address
    assign full_addr = {extended_io_bank_flag, io_addr};
    assign sel_vlc = (full_addr == ADDR_VOLTAGE_LEVEL_CONTROL);
    assign sel_vcs = (full_addr == ADDR_VOLTAGE_COMPARATOR_STATUS);
    assign sel_mdt = (full_addr == ADDR_MONITOR_DUTY_TRIM);
    assign io_hit = sel_vlc | sel_vcs | sel_mdt;

    // Writable fields; reserved bits are masked so they stay zero
    always_comb begin
        vlc_d = vlc_q;
        mdt_d = mdt_q;
        if (io_wr && sel_vlc) begin
            vlc_d = io_wdata & VLC_WMASK;
        end
        if (io_wr && sel_mdt) begin
            mdt_d = io_wdata & MDT_WMASK;
        end
    end

    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            vlc_q <= VLC_RESET;
            mdt_q <= MDT_RESET;
        end else if (ce) begin
            vlc_q <= vlc_d;
            mdt_q <= mdt_d;
        end
    end

    // Field outputs to the analog trip circuits
    assign reset_trip_range = vlc_q[RTR_LSB +: 2];
    assign undervoltage_trip_select = vlc_q[UTS_LSB +: 3];

    // Read mux, unmapped addresses and reserved bits read zero
    always_comb begin
        io_rdata = 8'h00;
        if (io_rd) begin
            if (sel_vlc) begin
                io_rdata = vlc_q;
            end else if (sel_vcs) begin
                io_rdata = vcs_q;
            end else if (sel_mdt) begin
                io_rdata = mdt_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sleep and wakeup sequencer
    // ------------------------------------------------------------------------
    swm_state_t state_q, state_d;
    logic [LAT_W-1:0] lat_q, lat_d;
    logic wake_seen_q, wake_seen_d;
    logic sample_now;

    always_comb begin
        state_d = state_q;
        lat_d = lat_q;
        wake_seen_d = wake_seen_q;
        sample_now = 1'b0;
        case (state_q)
            ST_AWAKE: begin
                if (sleep_set) begin
                    state_d = ST_REQ;
                end
            end
            ST_REQ: begin
                if (cpu_halt_acknowledge) begin
                    state_d = ST_ACKED;
                end
            end
            ST_ACKED: begin
                // One core cycle stands in for the falling-edge wait
                state_d = ST_SLEEP;
                wake_seen_d = 1'b0;
            end
            ST_SLEEP: begin
                // Interrupt is caught even if it ends before the slow edge
                if (irq_pending) begin
                    wake_seen_d = 1'b1;
                end
                if ((irq_pending || wake_seen_q) && ls_fall) begin
                    state_d = ST_SYNC;
                    lat_d = '0;
                end
            end
            ST_SYNC: begin
                if (ls_rise) begin
                    state_d = ST_PWRUP;
                end
            end
            ST_PWRUP: begin
                if (ls_rise) begin
                    state_d = ST_SAMPLED;
                    sample_now = 1'b1;
                end
            end
            ST_SAMPLED: begin
                // Hold release until the minimum latency; force it at the maximum
                if ((ls_fall && lat_q >= WAKE_MIN_CYC) || lat_q >= WAKE_MAX_CYC) begin
                    state_d = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (!cpu_halt_acknowledge) begin
                    state_d = ST_AWAKE;
                end
            end
            default: begin
                state_d = ST_AWAKE;
            end
        endcase
        if ((state_q == ST_SYNC || state_q == ST_PWRUP || state_q == ST_SAMPLED)
            && lat_q != WAKE_MAX_CYC) begin
            lat_d = lat_q + 12'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            state_q <= ST_AWAKE;
            lat_q <= '0;
            wake_seen_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            lat_q <= lat_d;
            wake_seen_q <= wake_seen_d;
        end
    end

    // Request rises in the same cycle as the sleep bit write
    assign cpu_halt_request = (state_q == ST_AWAKE && sleep_set)
        || state_q == ST_REQ || state_q == ST_ACKED || state_q == ST_SLEEP
        || state_q == ST_SYNC || state_q == ST_PWRUP || state_q == ST_SAMPLED;
    // Every powered-down block follows this one signal without firmware help
    assign global_power_down = (state_q == ST_SLEEP || state_q == ST_SYNC);
    assign wake_done = ce && state_q == ST_RELEASE && !cpu_halt_acknowledge;

    // ------------------------------------------------------------------------
    // Supply monitor duty cycle and comparator status
    // ------------------------------------------------------------------------
    swm_duty_gen u_duty (
        .ref_clk(ref_clk),
        .rst_n(srst_n),
        .ce(ce),
        .ls_rise(ls_rise),
        .duty_sel(mdt_q[DUTY_LSB +: 2]),
        .sleeping(global_power_down),
        .monitor_on(monitor_on)
    );
    assign monitor_enable = monitor_on;

    // Status tracks comparators live when awake except in ST_PWRUP, sampled at its end; in sleep only while the
    // monitor is powered, since its outputs are meaningless when off
    always_comb begin
        vcs_d = vcs_q;
        if (sample_now || (!global_power_down && state_q != ST_PWRUP)
            || (global_power_down && monitor_on)) begin
            vcs_d[STAT_LVD_BIT] = ls_sync_q[2];
            vcs_d[STAT_POR_BIT] = ls_sync_q[1];
        end
    end

    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            vcs_q <= VCS_RESET;
        end else if (ce) begin
            vcs_q <= vcs_d;
        end
    end

    // Level 11 reports the comparator but never resets
    assign precision_reset = vcs_q[STAT_POR_BIT] && reset_trip_range != RTR_NO_RESET;
    // Flash runs only when powered and supply is above the selected trip
    assign flash_enable = !global_power_down && !vcs_q[STAT_LVD_BIT];
    assign undervoltage_event = ce && vcs_d[STAT_LVD_BIT] && !vcs_q[STAT_LVD_BIT];
endmodule // swm_sleep_seq

/* rtl/swm_pkg.sv */
// Constants, register map and state codes for the sleep and wakeup sequencer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package swm_pkg;
    // ------------------------------------------------------------------------
    // Register map, full address is {bank flag, 8-bit offset}
    // ------------------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam logic [8:0] ADDR_VOLTAGE_LEVEL_CONTROL = 9'h1e3;
    localparam logic [8:0] ADDR_VOLTAGE_COMPARATOR_STATUS = 9'h1e4;
    localparam logic [8:0] ADDR_MONITOR_DUTY_TRIM = 9'h1eb;
    localparam logic [7:0] VLC_RESET = 8'h00;
    localparam logic [7:0] VCS_RESET = 8'h00;
    localparam logic [7:0] MDT_RESET = 8'h00;
    localparam logic [7:0] VLC_WMASK = 8'h37;
    localparam logic [7:0] MDT_WMASK = 8'hc0;
    // Field positions
    localparam int RTR_LSB = 4;
    localparam int UTS_LSB = 0;
    localparam int DUTY_LSB = 6;
    localparam int STAT_LVD_BIT = 1;
    localparam int STAT_POR_BIT = 0;
    localparam logic [1:0] RTR_RANGE_2V7 = 2'h0;
    localparam logic [1:0] RTR_RANGE_3V = 2'h1;
    localparam logic [1:0] RTR_NO_RESET = 2'h3;
    // Monitor duty periods, last count of each period in slow clock ticks
    localparam logic [1:0] DUTY_128 = 2'h0;
    localparam logic [1:0] DUTY_512 = 2'h1;
    localparam logic [1:0] DUTY_32 = 2'h2;
    localparam logic [1:0] DUTY_8 = 2'h3;
    localparam logic [8:0] DUTY_LAST_128 = 9'h07f;
    localparam logic [8:0] DUTY_LAST_512 = 9'h1ff;
    localparam logic [8:0] DUTY_LAST_32 = 9'h01f;
    localparam logic [8:0] DUTY_LAST_8 = 9'h007;
    // ------------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------------
    localparam longint CLK_HZ = 25000000;
    localparam longint WAKE_MIN_US = 75;
    localparam longint WAKE_MAX_US = 105;
    localparam int LAT_W = 12;
    localparam logic [11:0] WAKE_MIN_CYC = 12'((WAKE_MIN_US * CLK_HZ + 999999) / 1000000);
    localparam logic [11:0] WAKE_MAX_CYC = 12'((WAKE_MAX_US * CLK_HZ) / 1000000);
    // ------------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_AWAKE = 8'b00000001,
        ST_REQ = 8'b00000010,
        ST_ACKED = 8'b00000100,
        ST_SLEEP = 8'b00001000,
        ST_SYNC = 8'b00010000,
        ST_PWRUP = 8'b00100000,
        ST_SAMPLED = 8'b01000000,
        ST_RELEASE = 8'b10000000
    } swm_state_t;
endpackage

/* rtl/swm_duty_gen.sv */
// Supply monitor duty-cycle generator driven by slow clock ticks
`timescale 1ns/1ps
module swm_duty_gen (
    input wire logic ref_clk, // Core clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic ce, // Clock enable
    input wire logic ls_rise, // One-cycle pulse per slow clock period
    input wire logic [1:0] duty_sel, // Monitor sleep duty code
    input wire logic sleeping, // Duty cycling active
    output logic monitor_on // Monitor powered this period
);
    import swm_pkg::*;

    logic [8:0] cnt_q, cnt_d;
    logic [8:0] last;
    logic on_q, on_d;

    // ------------------------------------------------------------------------
    // Period length and counter
    // ------------------------------------------------------------------------
    // One slow period on, remainder of the period off
    always_comb begin
        case (duty_sel)
            DUTY_128: last = DUTY_LAST_128;
            DUTY_512: last = DUTY_LAST_512;
            DUTY_32: last = DUTY_LAST_32;
            default: last = DUTY_LAST_8;
        endcase
        cnt_d = cnt_q;
        on_d = on_q;
        if (!sleeping) begin
            cnt_d = 9'h000;
            on_d = 1'b1;
        end else if (ls_rise) begin
            cnt_d = (cnt_q >= last) ? 9'h000 : cnt_q + 9'h001;
            on_d = (cnt_d == 9'h000);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 9'h000;
            on_q <= 1'b1;
        end else if (ce) begin
            cnt_q <= cnt_d;
            on_q <= on_d;
        end
    end

    assign monitor_on = on_q;
endmodule // swm_duty_gen

/* tb/swm_sleep_seq_sva.sv */
// Port-level assertions for the sleep and wakeup sequencer
`timescale 1ns/1ps
module swm_sleep_seq_sva
    import swm_pkg::*;
(
    input wire logic ref_clk, // Core clock
    input wire logic rst_n, // Reset, active low
    input wire logic ce, // Clock enable
    input wire logic sleep_set, // Sleep bit pulse
    input wire logic irq_pending, // Unmasked interrupt
    input wire logic cpu_halt_acknowledge, // From CPU
    input wire logic low_speed_clk, // Slow clock
    input wire logic extended_io_bank_flag, // Bank select
    input wire logic [7:0] io_addr, // Offset
    input wire logic io_wr, // Write strobe
    input wire logic io_rd, // Read strobe
    input wire logic [7:0] io_wdata, // Write data
    input wire logic [7:0] io_rdata, // Read data
    input wire logic io_hit, // Address match
    input wire logic cpu_halt_request, // To CPU
    input wire logic global_power_down, // Power-down
    input wire logic [1:0] reset_trip_range, // Range field
    input wire logic [2:0] undervoltage_trip_select, // Trip field
    input wire logic precision_reset, // Reset out
    input wire logic flash_enable, // Flash gate
    input wire logic wake_done // Wake pulse
);
    // ------------------------------------------------------------------
    // Interrupt seen while powered down
    // ------------------------------------------------------------------
    logic irq_seen_q;
    logic irq_seen_d;
    always_comb begin
        irq_seen_d = global_power_down & (irq_seen_q | irq_pending);
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_seen_q <= 1'b0;
        end else begin
            irq_seen_q <= irq_seen_d;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Wake pulse excluded: the leaving-release cycle ignores the sleep bit
    a_req_at_once: assert property (
        ce && sleep_set && !cpu_halt_acknowledge && !global_power_down && !wake_done
        && !$past(cpu_halt_request) |-> cpu_halt_request) else $error("halt request late");
    a_pd_after_ack: assert property (
        ce && $rose(cpu_halt_acknowledge) && cpu_halt_request
        |-> !global_power_down ##1 !global_power_down ##1 global_power_down)
        else $error("power-down timing off");
    a_wake_by_irq: assert property (
        $fell(global_power_down) |-> irq_seen_q) else $error("woke without interrupt");
    a_pd_off_rise: assert property (
        $fell(global_power_down) |-> low_speed_clk) else $error("power-up off slow rise");
    a_req_in_pd: assert property (
        global_power_down |-> cpu_halt_request) else $error("request dropped asleep");
    a_flash_off: assert property (
        global_power_down |-> !flash_enable) else $error("flash on in power-down");
    a_no_reset_11: assert property (
        reset_trip_range == RTR_NO_RESET |-> !precision_reset) else $error("reset at code 11");
    a_bank_needed: assert property (
        !extended_io_bank_flag |-> !io_hit) else $error("hit in first bank");
    a_idle_rdata: assert property (
        !(io_rd && io_hit) |-> io_rdata == 8'h00) else $error("read data not zero");
    a_reserved_zero: assert property (
        io_rd && io_hit |-> (io_rdata & ~(io_addr == 8'he3 ? VLC_WMASK :
        io_addr == 8'heb ? MDT_WMASK : 8'h03)) == 8'h00) else $error("reserved bit set");
    a_fields_written: assert property (
        ce && io_wr && io_hit && io_addr == 8'he3 |=> {2'b00, reset_trip_range, 1'b0,
        undervoltage_trip_select} == ($past(io_wdata) & VLC_WMASK))
        else $error("fields not written");
    // Once the request is gone and the CPU lets go, the release must end that cycle
    a_wake_done_idle: assert property (
        $fell(cpu_halt_request) ##1 !cpu_halt_acknowledge |-> wake_done)
        else $error("no wake pulse");
endmodule // swm_sleep_seq_sva

bind swm_sleep_seq swm_sleep_seq_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .sleep_set(sleep_set), .irq_pending(irq_pending),
    .cpu_halt_acknowledge(cpu_halt_acknowledge), .low_speed_clk(low_speed_clk),
    .extended_io_bank_flag(extended_io_bank_flag), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
    .cpu_halt_request(cpu_halt_request), .global_power_down(global_power_down),
    .reset_trip_range(reset_trip_range), .undervoltage_trip_select(undervoltage_trip_select),
    .precision_reset(precision_reset), .flash_enable(flash_enable), .wake_done(wake_done));

/* tb/swm_cpu_model.sv */
// Behavioural CPU halt handshake partner
`timescale 1ns/1ps
module swm_cpu_model (
    input wire logic ref_clk, // Core clock
    input wire logic rst_n, // Reset, active low
    input wire logic slow, // Delay the acknowledge
    input wire logic cpu_halt_request, // From sequencer
    output logic cpu_halt_acknowledge // To sequencer
);
    logic [2:0] wait_q;
    // Slow mode mimics a CPU finishing a long instruction first
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_halt_acknowledge <= 1'b0;
            wait_q <= 3'h0;
        end else if (!cpu_halt_request) begin
            cpu_halt_acknowledge <= 1'b0;
            wait_q <= 3'h0;
        end else if (wait_q >= (slow ? 3'h4 : 3'h0)) begin
            cpu_halt_acknowledge <= 1'b1;
        end else begin
            wait_q <= wait_q + 3'h1;
        end
    end
endmodule // swm_cpu_model

/* tb/swm_tb_top.sv */
// Self-checking testbench for the sleep and wakeup sequencer
`timescale 1ns/1ps
module swm_tb_top;
    import swm_pkg::*;
    logic ref_clk, rst_n, ce, sleep_set, irq_pending, cpu_halt_acknowledge, low_speed_clk;
    logic precision_reset_comparator, undervoltage_detect, extended_io_bank_flag, io_wr, io_rd;
    logic [7:0] io_addr, io_wdata, io_rdata, rv;
    logic io_hit, cpu_halt_request, global_power_down, monitor_enable, slow;
    logic [1:0] reset_trip_range;
    logic [2:0] undervoltage_trip_select;
    logic precision_reset, flash_enable, undervoltage_event, wake_done;
    int err_count, comparisons, cycles, uv_events;
    swm_sleep_seq u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .sleep_set(sleep_set),
        .irq_pending(irq_pending), .cpu_halt_acknowledge(cpu_halt_acknowledge),
        .low_speed_clk(low_speed_clk),
        .precision_reset_comparator(precision_reset_comparator),
        .undervoltage_detect(undervoltage_detect),
        .extended_io_bank_flag(extended_io_bank_flag),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_hit(io_hit), .cpu_halt_request(cpu_halt_request),
        .global_power_down(global_power_down), .monitor_enable(monitor_enable),
        .reset_trip_range(reset_trip_range),
        .undervoltage_trip_select(undervoltage_trip_select),
        .precision_reset(precision_reset), .flash_enable(flash_enable),
        .undervoltage_event(undervoltage_event), .wake_done(wake_done));
    swm_cpu_model u_cpu (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
        .cpu_halt_request(cpu_halt_request), .cpu_halt_acknowledge(cpu_halt_acknowledge));
    // ------------------------------------------------------------------
    // Clocks and hang guard
    // ------------------------------------------------------------------
    always #20 ref_clk = ~ref_clk;
    always #15625 low_speed_clk = ~low_speed_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (undervoltage_event === 1'b1) begin
            uv_events++;
        end
        if (cycles == 30000) begin
            err_count++;
            conclude();
        end
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One register access; read data is taken at the edge that ends the request
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        io_wr <= w;
        io_rd <= !w;
        io_addr <= a;
        io_wdata <= d;
        @(posedge ref_clk);
        rv = io_rdata;
        io_wr <= 1'b0;
        io_rd <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        acc(1'b0, a, 8'h00);
        chk(what, rv, exp);
    endtask
    task automatic conclude();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rd(8'he3, VLC_RESET, "level reset");
        rd(8'he4, VCS_RESET, "status reset");
        rd(8'heb, MDT_RESET, "duty reset");
        acc(1'b1, 8'he3, 8'hff);
        rd(8'he3, VLC_WMASK, "level reserved");
        chk("range out", 8'(reset_trip_range), 8'h03);
        acc(1'b1, 8'heb, 8'hff);
        rd(8'heb, MDT_WMASK, "duty reserved");
        chk("hit", 8'(io_hit), 8'h01);
        acc(1'b1, 8'he4, 8'hff);
        rd(8'he4, 8'h00, "status write");
        rd(8'he5, 8'h00, "unmapped");
        extended_io_bank_flag <= 1'b0;
        rd(8'he3, 8'h00, "first bank");
        chk("no hit", 8'(io_hit), 8'h00);
        extended_io_bank_flag <= 1'b1;
    endtask
    task automatic t_levels();
        precision_reset_comparator <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            acc(1'b1, 8'he3, 8'(r << 4));
            repeat (4) @(posedge ref_clk);
            chk("reset out", 8'(precision_reset), 8'(r != 3));
            rd(8'he4, 8'h01, "reset comparator");
        end
        precision_reset_comparator <= 1'b0;
        undervoltage_detect <= 1'b1;
        for (int v = 0; v < 8; v++) begin
            acc(1'b1, 8'he3, 8'(v) | 8'hc8);
            rd(8'he3, 8'(v), "trip select");
        end
        chk("flash gate", 8'(flash_enable), 8'h00);
        rd(8'he4, 8'h02, "undervoltage");
        undervoltage_detect <= 1'b0;
        for (int d = 0; d < 4; d++) begin
            acc(1'b1, 8'heb, 8'(d << 6) | 8'h3f);
            rd(8'heb, 8'(d << 6), "duty");
        end
        chk("undervoltage event", 8'(uv_events), 8'h01);
    endtask
    // Firmware pin, timer-clock and core-clock setup lies outside this block
    // Irq is raised just before a slow falling edge so the bound is reachable
    task automatic t_sleep(input logic s);
        int n;
        slow <= s;
        sleep_set <= 1'b1;
        @(negedge ref_clk);
        chk("request at once", 8'(cpu_halt_request), 8'h01);
        chk("monitor awake", 8'(monitor_enable), 8'h01);
        @(posedge ref_clk);
        sleep_set <= 1'b0;
        repeat (1000) @(posedge ref_clk);
        sleep_set <= 1'b1;
        @(posedge ref_clk);
        sleep_set <= 1'b0;
        @(negedge ref_clk);
        chk("asleep", 8'({global_power_down, cpu_halt_request}), 8'h03);
        @(posedge low_speed_clk);
        repeat (380) @(posedge ref_clk);
        // Duty code 11 leaves the monitor off after its first slow period
        chk("monitor duty", 8'(monitor_enable), 8'h00);
        irq_pending <= 1'b1;
        n = 0;
        while (cpu_halt_request === 1'b1 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        chk("latency", 8'(n >= WAKE_MIN_CYC && n <= WAKE_MAX_CYC), 8'h01);
        while (wake_done !== 1'b1 && n < 4010) begin
            @(negedge ref_clk);
            n++;
        end
        chk("wake pulse", 8'(wake_done), 8'h01);
        chk("awake", 8'({global_power_down, cpu_halt_acknowledge}), 8'h00);
        chk("monitor after", 8'(monitor_enable), 8'h01);
        @(posedge ref_clk);
        irq_pending <= 1'b0;
    endtask
    initial begin
        {ref_clk, low_speed_clk, rst_n, sleep_set, irq_pending, slow} = '0;
        {precision_reset_comparator, undervoltage_detect, io_wr, io_rd} = '0;
        {io_addr, io_wdata} = '0;
        ce = 1'b1;
        extended_io_bank_flag = 1'b1;
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        uv_events = 0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_regs();
        t_levels();
        t_sleep(1'b0);
        t_sleep(1'b1);
        conclude();
    end
endmodule // swm_tb_top
